// file: verilog/iat_regs.svh
// Purpose: Register offsets, field positions and reset values of the adapter
// Assumes: Included by bare name from the design files
// Notes:   Offsets are register-select codes, one byte per location
`ifndef IAT_REGS_SVH
`define IAT_REGS_SVH

// ==========================================================
// Register-select offsets
`define IAT_OFF_PA_DATA 4'h0
`define IAT_OFF_PB_DATA 4'h1
`define IAT_OFF_PA_DIR 4'h2
`define IAT_OFF_PB_DIR 4'h3
`define IAT_OFF_TA_LO 4'h4
`define IAT_OFF_TA_HI 4'h5
`define IAT_OFF_TB_LO 4'h6
`define IAT_OFF_TB_HI 4'h7
`define IAT_OFF_EV_LO 4'h8
`define IAT_OFF_EV_MID 4'h9
`define IAT_OFF_EV_HI 4'ha
`define IAT_OFF_NC 4'hb
`define IAT_OFF_SHIFT 4'hc
`define IAT_OFF_IRQ 4'hd
`define IAT_OFF_TA_CTRL 4'he
`define IAT_OFF_TB_CTRL 4'hf

// ==========================================================
// Timer control fields
`define IAT_CR_START 0
`define IAT_CR_PIN_EN 1
`define IAT_CR_TOGGLE 2
`define IAT_CR_ONESHOT 3
`define IAT_CR_LOAD 4
`define IAT_CR_SRC_LO 5
`define IAT_CR_SRC_HI 6

// ==========================================================
// Request flag positions, reset values, strobe delay
`define IAT_FLG_TA 0
`define IAT_FLG_TB 1
`define IAT_FLG_EDGE 4
`define IAT_LATCH_RST 16'hffff
`define IAT_HS_STAGES 2

`endif

// file: verilog/iat_pkg.sv
// Purpose: Shared types of the adapter
// Assumes: Nothing
// Notes:   Offsets and fields live in iat_regs.svh
package iat_pkg;
    // ==========================================================
    // Timer B count source select
    typedef enum logic [1:0] {
        IAT_SRC_CLK = 2'b00,
        IAT_SRC_EXT = 2'b01,
        IAT_SRC_TA = 2'b10,
        IAT_SRC_TA_EXT = 2'b11
    } iat_src_type;
    typedef logic [7:0] iat_byte_type;
endpackage

// file: verilog/iat_port.sv
// Purpose: One bidirectional port with data and direction registers
// Assumes: Pins synchronous to clk
// Notes:   Override lanes let timers take a pin regardless of direction
`timescale 1ns/1ps
module iat_port #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] ovr_en,
    input wire logic [WIDTH-1:0] ovr_val,
    output logic [WIDTH-1:0] dir_q,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe
);
    logic [WIDTH-1:0] data_q;

    // ==========================================================
    // Output data and direction registers, cleared by reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_q <= '0;
        end else if (wr_data) begin
            data_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dir_q <= '0;
        end else if (wr_dir) begin
            dir_q <= wdata;
        end
    end

    // Direction one drives the pin; override forces drive
    assign pin_oe = dir_q | ovr_en;
    assign pin_out = (ovr_en & ovr_val) | (~ovr_en & data_q);
endmodule

// file: verilog/iat_timer.sv
// Purpose: One 16-bit interval timer with reload latch and control byte
// Assumes: tick is a one-cycle count request from the selected source
// Notes:   Underflow means counting down past zero
`timescale 1ns/1ps
`include "iat_regs.svh"
module iat_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic wr_ctrl,
    input wire logic [7:0] wdata,
    input wire logic tick,
    output logic [15:0] count_q,
    output logic [7:0] ctrl_q,
    output logic underflow,
    output logic pin_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [15:0] latch_q;
    logic toggle_q;
    logic pulse_q;
    logic running;
    logic oneshot;
    logic hi_load;
    logic force_load;
    logic starting;

    assign running = ctrl_q[`IAT_CR_START];
    assign oneshot = ctrl_q[`IAT_CR_ONESHOT];
    assign underflow = running & tick & (count_q == 16'h0000);
    // High byte reloads when stopped, or always in one-shot
    assign hi_load = wr_hi & (~running | oneshot);
    assign force_load = wr_ctrl & wdata[`IAT_CR_LOAD];
    assign starting = ~running & ((wr_ctrl & wdata[`IAT_CR_START]) | (wr_hi & oneshot));

    // ==========================================================
    // Write-only reload latch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_q <= `IAT_LATCH_RST;
        end else begin
            if (wr_lo) begin
                latch_q[7:0] <= wdata;
            end
            if (wr_hi) begin
                latch_q[15:8] <= wdata;
            end
        end
    end

    // Down counter; loads win over counting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= `IAT_LATCH_RST;
        end else if (force_load) begin
            count_q <= latch_q;
        end else if (hi_load) begin
            count_q <= {wdata, latch_q[7:0]};
        end else if (underflow) begin
            count_q <= latch_q;
        end else if (running & tick) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // Control byte; load strobe is not stored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 8'h00;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata & ~(8'h01 << `IAT_CR_LOAD);
        end else if (hi_load & oneshot) begin
            ctrl_q[`IAT_CR_START] <= 1'b1;
        end else if (underflow & oneshot) begin
            ctrl_q[`IAT_CR_START] <= 1'b0;
        end
    end

    // Pin output: toggle or one-cycle pulse per underflow
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggle_q <= 1'b0;
        end else if (starting) begin
            toggle_q <= 1'b1;
        end else if (underflow) begin
            toggle_q <= ~toggle_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= underflow;
        end
    end

    assign pin_q = ctrl_q[`IAT_CR_TOGGLE] ? toggle_q : pulse_q;

    // ==========================================================
    // Checks
    property p_reload;
        underflow && !force_load && !hi_load |=> count_q == $past(latch_q);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload on underflow");

    property p_countdown;
        running && tick && count_q != 16'h0000 && !wr_ctrl && !wr_hi
            |=> count_q == $past(count_q) - 16'h0001;
    endproperty
    a_countdown: assert property (p_countdown) else $error("count did not step");

    property p_hold_stopped;
        !running && !wr_ctrl && !wr_hi |=> count_q == $past(count_q);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("stopped timer moved");

    property p_oneshot_hi;
        wr_hi && oneshot && !wr_ctrl
            |=> count_q == {$past(wdata), latch_q[7:0]} && running;
    endproperty
    a_oneshot_hi: assert property (p_oneshot_hi) else $error("one-shot hi no start");

    property p_pulse;
        underflow && !ctrl_q[`IAT_CR_TOGGLE] && !wr_ctrl ##1 !underflow && !wr_ctrl |=> !pin_q;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse longer than a cycle");

    c_oneshot_end: cover property (underflow && oneshot ##1 !running);
endmodule

// file: verilog/iat_core.sv
// Purpose: Interface adapter core with two ports, handshake and two timers
// Assumes: Register select and pins synchronous to clk; one access per cycle
// Notes:   Event counter, shift buffer and offset B locations read as zero
//
// Overview of operation
// - Four select lines decode sixteen byte locations; offset B does nothing.
// - Each port has data and direction registers; direction one drives.
// - Port data reads return present pin levels, input or output.
// - Handshake strobe goes low third cycle after a port B access.
// - Every falling edge on the flag input sets its request bit.
// - Timer byte writes go to the latch; reads return the counter.
// - Run bit starts or stops counting whenever the host writes it.
// - Pin enable puts timer A on port B bit six, B on seven.
// - Underflow either toggles the pin or emits a one-cycle high pulse.
// - Toggle output goes high on timer start, low on reset.
// - One-shot counts to zero, flags, reloads, then stops.
// - Continuous mode counts to zero, flags, reloads and repeats.
// - One-shot high-byte write loads counter and starts, ignoring run bit.
// - Force-load strobe copies latch to counter at once.
// - Timer A counts clock cycles or external count-pin rises.
// - Timer B counts clock, pin rises, A underflows, or gated A underflows.
// - Counter reloads on underflow, force load, stopped high-byte write.
// - Running continuous-mode timer high-byte write changes only the latch.
// - Run bit clears itself on one-shot underflow.
// - Counting past zero is underflow and sets that timer's request bit.
`timescale 1ns/1ps
`include "iat_regs.svh"
module iat_core (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] register_select_lines,
    input wire logic bus_access,
    input wire logic bus_read,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    input wire logic external_count_pin,
    input wire logic edge_flag_n,
    output logic handshake_strobe_out_n,
    output logic [4:0] irq_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Decode helpers

    // One access at the given select code this cycle
    function automatic logic hit(input logic [3:0] sel, input logic [3:0] off);
        hit = bus_access & (sel == off);
    endfunction

    logic wr_en;
    logic rd_en;
    logic [3:0] sel;
    assign sel = register_select_lines;
    assign wr_en = bus_access & ~bus_read;
    assign rd_en = bus_access & bus_read;

    // ==========================================================
    // Edge detection on count and flag pins

    logic ext_prev_q;
    logic flag_prev_q;
    logic ext_rise;
    logic flag_fall;

    // Pins are synchronous, so one stage of history is enough
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_prev_q <= 1'b1;
            flag_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= external_count_pin;
            flag_prev_q <= edge_flag_n;
        end
    end

    assign ext_rise = external_count_pin & ~ext_prev_q;
    assign flag_fall = flag_prev_q & ~edge_flag_n;

    // ==========================================================
    // Timers

    logic [1:0] tmr_wr_lo;
    logic [1:0] tmr_wr_hi;
    logic [1:0] tmr_wr_ctrl;
    logic [1:0] tmr_tick;
    logic [1:0] tmr_uflow;
    logic [1:0] tmr_pin;
    logic [15:0] tmr_count [2];
    logic [7:0] tmr_ctrl [2];
    iat_pkg::iat_src_type b_src;

    // Timer B source from its two select bits
    assign b_src = iat_pkg::iat_src_type'(tmr_ctrl[1][`IAT_CR_SRC_HI:`IAT_CR_SRC_LO]);

    // Tick of each timer from its selected source
    always_comb begin
        tmr_tick[0] = tmr_ctrl[0][`IAT_CR_SRC_LO] ? ext_rise : 1'b1;
        case (b_src)
            iat_pkg::IAT_SRC_CLK: tmr_tick[1] = 1'b1;
            iat_pkg::IAT_SRC_EXT: tmr_tick[1] = ext_rise;
            iat_pkg::IAT_SRC_TA: tmr_tick[1] = tmr_uflow[0];
            iat_pkg::IAT_SRC_TA_EXT: tmr_tick[1] = tmr_uflow[0] & external_count_pin;
            default: tmr_tick[1] = 1'b0;
        endcase
    end

    // Both timers share one structure; byte offsets step by two, control by one
    generate
        for (genvar i = 0; i < 2; i++) begin : g_tmr
            assign tmr_wr_lo[i] = wr_en & hit(sel, `IAT_OFF_TA_LO + 4'(2 * i));
            assign tmr_wr_hi[i] = wr_en & hit(sel, `IAT_OFF_TA_HI + 4'(2 * i));
            assign tmr_wr_ctrl[i] = wr_en & hit(sel, `IAT_OFF_TA_CTRL + 4'(i));

            iat_timer u_tmr (
                .clk(clk),
                .rstn(rstn),
                .wr_lo(tmr_wr_lo[i]),
                .wr_hi(tmr_wr_hi[i]),
                .wr_ctrl(tmr_wr_ctrl[i]),
                .wdata(bus_wdata),
                .tick(tmr_tick[i]),
                .count_q(tmr_count[i]),
                .ctrl_q(tmr_ctrl[i]),
                .underflow(tmr_uflow[i]),
                .pin_q(tmr_pin[i])
            );
        end
    endgenerate

    // ==========================================================
    // Ports

    logic [7:0] prt_dir [2];
    logic [7:0] prt_out [2];
    logic [7:0] prt_oe [2];
    logic [7:0] prt_ovr_en [2];
    logic [7:0] prt_ovr_val [2];

    // Port A has no override; port B bits six and seven carry timers
    assign prt_ovr_en[0] = 8'h00;
    assign prt_ovr_val[0] = 8'h00;
    assign prt_ovr_en[1] = {tmr_ctrl[1][`IAT_CR_PIN_EN], tmr_ctrl[0][`IAT_CR_PIN_EN], 6'h00};
    assign prt_ovr_val[1] = {tmr_pin[1], tmr_pin[0], 6'h00};

    generate
        for (genvar p = 0; p < 2; p++) begin : g_prt
            iat_port #(
                .WIDTH(8)
            ) u_prt (
                .clk(clk),
                .rstn(rstn),
                .wr_data(wr_en & hit(sel, `IAT_OFF_PA_DATA + 4'(p))),
                .wr_dir(wr_en & hit(sel, `IAT_OFF_PA_DIR + 4'(p))),
                .wdata(bus_wdata),
                .ovr_en(prt_ovr_en[p]),
                .ovr_val(prt_ovr_val[p]),
                .dir_q(prt_dir[p]),
                .pin_out(prt_out[p]),
                .pin_oe(prt_oe[p])
            );
        end
    endgenerate

    assign port_a_out = prt_out[0];
    assign port_a_oe = prt_oe[0];
    assign port_b_out = prt_out[1];
    assign port_b_oe = prt_oe[1];

    // ==========================================================
    // Handshake strobe

    logic pb_access;
    logic [`IAT_HS_STAGES-1:0] hs_pipe_q;

    assign pb_access = hit(sel, `IAT_OFF_PB_DATA);

    // Two-stage delay then a registered strobe lands on the third cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_pipe_q <= '0;
        end else begin
            hs_pipe_q <= {hs_pipe_q[`IAT_HS_STAGES-2:0], pb_access};
        end
    end

    // Low for one cycle per access, high at rest
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            handshake_strobe_out_n <= 1'b1;
        end else begin
            handshake_strobe_out_n <= ~hs_pipe_q[`IAT_HS_STAGES-1];
        end
    end

    // ==========================================================
    // Request flags, cleared by reading offset D; a new event wins

    logic [4:0] flags_q;
    logic [4:0] flag_set;
    logic flag_clr;

    assign flag_set = {flag_fall, 2'b00, tmr_uflow[1], tmr_uflow[0]};
    assign flag_clr = rd_en & hit(sel, `IAT_OFF_IRQ);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= 5'h00;
        end else begin
            flags_q <= (flag_clr ? 5'h00 : flags_q) | flag_set;
        end
    end

    assign irq_flags = flags_q;

    // ==========================================================
    // Read data, registered one cycle after the access

    iat_pkg::iat_byte_type rd_mux;

    always_comb begin
        if (sel == `IAT_OFF_PA_DATA) begin
            rd_mux = port_a_in;
        end else if (sel == `IAT_OFF_PB_DATA) begin
            rd_mux = port_b_in;
        end else if (sel == `IAT_OFF_PA_DIR) begin
            rd_mux = prt_dir[0];
        end else if (sel == `IAT_OFF_PB_DIR) begin
            rd_mux = prt_dir[1];
        end else if (sel == `IAT_OFF_TA_LO) begin
            rd_mux = tmr_count[0][7:0];
        end else if (sel == `IAT_OFF_TA_HI) begin
            rd_mux = tmr_count[0][15:8];
        end else if (sel == `IAT_OFF_TB_LO) begin
            rd_mux = tmr_count[1][7:0];
        end else if (sel == `IAT_OFF_TB_HI) begin
            rd_mux = tmr_count[1][15:8];
        end else if (sel == `IAT_OFF_IRQ) begin
            rd_mux = {3'b000, flags_q};
        end else if (sel == `IAT_OFF_TA_CTRL) begin
            rd_mux = tmr_ctrl[0];
        end else if (sel == `IAT_OFF_TB_CTRL) begin
            rd_mux = tmr_ctrl[1];
        end else begin
            rd_mux = 8'h00; // offset B and absent blocks
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= 8'h00;
        end else if (rd_en) begin
            bus_rdata <= rd_mux;
        end
    end

    // ==========================================================
    // Checks

    property p_hs_delay;
        pb_access |-> ##3 !handshake_strobe_out_n;
    endproperty
    a_hs_delay: assert property (p_hs_delay) else $error("strobe not low 3rd cycle");

    property p_hs_return;
        $fell(handshake_strobe_out_n) && !$past(pb_access, 2) |=> handshake_strobe_out_n;
    endproperty
    a_hs_return: assert property (p_hs_return) else $error("strobe stayed low");

    property p_flag_edge;
        $fell(edge_flag_n) |=> flags_q[`IAT_FLG_EDGE];
    endproperty
    a_flag_edge: assert property (p_flag_edge) else $error("flag edge lost");

    property p_uflow_flag;
        tmr_uflow[0] |=> flags_q[`IAT_FLG_TA];
    endproperty
    a_uflow_flag: assert property (p_uflow_flag) else $error("underflow flag lost");

    property p_oneshot_stop;
        tmr_uflow[1] && tmr_ctrl[1][`IAT_CR_ONESHOT] && !tmr_wr_ctrl[1] && !tmr_wr_hi[1]
            |=> !tmr_ctrl[1][`IAT_CR_START];
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

    property p_pin_read;
        rd_en && sel == `IAT_OFF_PA_DATA |=> bus_rdata == $past(port_a_in);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("port read not pin level");

    property p_pb6_drive;
        tmr_ctrl[0][`IAT_CR_PIN_EN] |-> port_b_oe[6] && port_b_out[6] == tmr_pin[0];
    endproperty
    a_pb6_drive: assert property (p_pb6_drive) else $error("timer A not on pin");

    property p_b_chain;
        b_src == iat_pkg::IAT_SRC_TA && tmr_ctrl[1][`IAT_CR_START] && !tmr_uflow[0]
            && !tmr_wr_ctrl[1] && !tmr_wr_hi[1] |=> $stable(tmr_count[1]);
    endproperty
    a_b_chain: assert property (p_b_chain) else $error("chained B moved alone");

    property p_uflow_flag_b;
        tmr_uflow[1] |=> flags_q[`IAT_FLG_TB];
    endproperty
    a_uflow_flag_b: assert property (p_uflow_flag_b) else $error("B flag lost");

    property p_pb7_drive;
        tmr_ctrl[1][`IAT_CR_PIN_EN] |-> port_b_oe[7] && port_b_out[7] == tmr_pin[1];
    endproperty
    a_pb7_drive: assert property (p_pb7_drive) else $error("timer B not on pin");

    property p_pin_read_b;
        rd_en && sel == `IAT_OFF_PB_DATA |=> bus_rdata == $past(port_b_in);
    endproperty
    a_pin_read_b: assert property (p_pin_read_b) else $error("port B read wrong");

    property p_dir_write;
        wr_en && sel == `IAT_OFF_PA_DIR |=> port_a_oe == $past(bus_wdata);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not set");

    property p_hs_rest;
        !pb_access |-> ##3 handshake_strobe_out_n;
    endproperty
    a_hs_rest: assert property (p_hs_rest) else $error("strobe low unasked");

    c_hs: cover property (pb_access ##3 !handshake_strobe_out_n ##1 handshake_strobe_out_n);
    c_flag: cover property (flag_fall ##1 flag_clr);
    c_cont: cover property (tmr_uflow[0] && !tmr_ctrl[0][`IAT_CR_ONESHOT]);
    c_chain: cover property (b_src == iat_pkg::IAT_SRC_TA && tmr_uflow[0]);
endmodule

// file: sim/iat_pins.sv
// Purpose: Peripheral side of both ports, resolving each pin wire
// Assumes: Peripheral drives a pin only where ext_en is high
// Notes:   Pins driven by no one float high through passive pull-ups
`timescale 1ns/1ps
module iat_pins (
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_en,
    output logic [7:0] a_pin,
    output logic [7:0] b_pin
);
    // ==========================================================
    // Wire levels: device driver, else peripheral, else pull-up
    assign a_pin = (a_out & a_oe) | (~a_oe & ((ext_a & ext_en) | ~ext_en));
    assign b_pin = (b_out & b_oe) | (~b_oe & ((ext_b & ext_en) | ~ext_en));
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the interface adapter core
// Assumes: One host access per two cycles, inputs driven at edges
// Notes:   Random port traffic from a fixed seed plus timer corner cases
`timescale 1ns/1ps
module tb_top;
    logic clk, rstn, bus_access, bus_read, ext_pin, flag_n, strobe_n;
    logic [3:0] sel;
    logic [4:0] irq;
    logic [7:0] wdata, rdata, a_out, a_oe, b_out, b_oe, a_pin, b_pin;
    logic [7:0] ext_a, ext_b, ext_en, d, dir;
    int error_cnt, tests_run, n;
    integer seed;

    // ==========================================================
    // Design and peripheral model
    iat_core DUT (.clk(clk), .rstn(rstn), .register_select_lines(sel),
        .bus_access(bus_access), .bus_read(bus_read), .bus_wdata(wdata),
        .bus_rdata(rdata), .port_a_in(a_pin), .port_a_out(a_out), .port_a_oe(a_oe),
        .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe(b_oe),
        .external_count_pin(ext_pin), .edge_flag_n(flag_n),
        .handshake_strobe_out_n(strobe_n), .irq_flags(irq));
    iat_pins pins (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .ext_a(ext_a), .ext_b(ext_b), .ext_en(ext_en), .a_pin(a_pin), .b_pin(b_pin));

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end

    // ==========================================================
    // Bus access, comparison and expectation helpers
    task automatic acc(input logic [3:0] s, input logic r, input logic [7:0] w);
        @(posedge clk);
        sel <= s;
        bus_read <= r;
        wdata <= w;
        bus_access <= 1'b1;
        @(posedge clk);
        bus_access <= 1'b0;
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] s, input logic [7:0] exp);
        acc(s, 1'b1, 8'h00);
        chk($sformatf("reg %h", s), {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic edges(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] pin_exp(logic [7:0] dd, dr, e, en);
        return (dd & dr) | (~dr & ((e & en) | ~en));
    endfunction
    task automatic end_sim;
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'hd185a80d;
        rstn = 1'b0;
        bus_access = 1'b0;
        bus_read = 1'b0;
        sel = 4'h0;
        wdata = 8'h00;
        ext_pin = 1'b0;
        flag_n = 1'b1;
        ext_a = 8'h00;
        ext_b = 8'h00;
        ext_en = 8'h00;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        edges(1);
        // Reset state
        chk("a_oe", 16'h0, {8'h00, a_oe});
        chk("strobe", 16'h1, {15'h0, strobe_n});
        for (int i = 4; i < 8; i++) begin
            rd(i[3:0], 8'hff);
        end
        rd(4'he, 8'h00);
        // Unconnected location
        acc(4'hb, 1'b0, 8'h5a);
        rd(4'hb, 8'h00);
        // Falling flag edge sets its request, read clears it
        rd(4'hd, 8'h00);
        @(posedge clk);
        flag_n <= 1'b0;
        edges(2);
        rd(4'hd, 8'h10);
        rd(4'hd, 8'h00);
        // Random port traffic, all-in and all-out corners first
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            dir = $random(seed);
            if (i < 2) dir = {8{i[0]}};
            @(posedge clk);
            ext_a <= $random(seed);
            ext_b <= $random(seed);
            ext_en <= $random(seed);
            acc(4'h2, 1'b0, dir);
            acc(4'h0, 1'b0, d);
            acc(4'h3, 1'b0, dir);
            acc(4'h1, 1'b0, d);
            chk("a_oe", {8'h00, dir}, {8'h00, a_oe});
            rd(4'h0, pin_exp(d, dir, ext_a, ext_en));
            rd(4'h1, pin_exp(d, dir, ext_b, ext_en));
        end
        // Handshake strobe after a word, port A first
        edges(4);
        acc(4'h0, 1'b0, 8'h00);
        acc(4'h1, 1'b0, 8'h00);
        edges(1);
        chk("hs c2", 16'h1, {15'h0, strobe_n});
        edges(1);
        chk("hs c3", 16'h0, {15'h0, strobe_n});
        edges(1);
        chk("hs c4", 16'h1, {15'h0, strobe_n});
        // Timer A one-shot of five
        acc(4'h4, 1'b0, 8'h05);
        acc(4'h5, 1'b0, 8'h00);
        rd(4'h4, 8'h05);
        rd(4'h5, 8'h00);
        acc(4'he, 1'b0, 8'h09);
        n = 0;
        while (irq[0] !== 1'b1 && n < 50) begin
            edges(1);
            n++;
        end
        chk("ta span", 16'd6, n[15:0]);
        rd(4'he, 8'h08);
        rd(4'h4, 8'h05);
        acc(4'h5, 1'b0, 8'h00);
        rd(4'he, 8'h09);
        edges(10);
        rd(4'he, 8'h08);
        // Continuous toggle every four cycles (period eight) on port B bit six
        acc(4'he, 1'b0, 8'h00);
        acc(4'h3, 1'b0, 8'h00);
        acc(4'h4, 1'b0, 8'h03);
        acc(4'h5, 1'b0, 8'h00);
        acc(4'he, 1'b0, 8'h07);
        edges(1);
        chk("pb6 oe", 16'h1, {15'h0, b_oe[6]});
        chk("pb6 start", 16'h1, {15'h0, b_out[6]});
        n = 0;
        while (b_out[6] === 1'b1 && n < 20) begin
            edges(1);
            n++;
        end
        n = 0;
        while (b_out[6] === 1'b0 && n < 20) begin
            edges(1);
            n++;
        end
        chk("pb6 period", 16'd4, n[15:0]);
        // Running high-byte write, then force load
        acc(4'h4, 1'b0, 8'h40);
        acc(4'he, 1'b0, 8'h00);
        acc(4'h5, 1'b0, 8'h00);
        acc(4'he, 1'b0, 8'h01);
        acc(4'h5, 1'b0, 8'h10);
        rd(4'h5, 8'h00);
        acc(4'he, 1'b0, 8'h11);
        rd(4'h5, 8'h10);
        rd(4'he, 8'h01);
        acc(4'he, 1'b0, 8'h00);
        // Timer B single-cycle pulse on port B bit seven
        acc(4'h6, 1'b0, 8'h02);
        acc(4'h7, 1'b0, 8'h00);
        acc(4'hf, 1'b0, 8'h03);
        n = 0;
        while (b_out[7] !== 1'b1 && n < 20) begin
            edges(1);
            n++;
        end
        chk("pb7 oe", 16'h1, {15'h0, b_oe[7]});
        edges(1);
        chk("pb7 pulse", 16'h0, {15'h0, b_out[7]});
        chk("tb irq", 16'h1, {15'h0, irq[1]});
        acc(4'hf, 1'b0, 8'h00);
        // Both timers counting five count-pin rises
        acc(4'h4, 1'b0, 8'h20);
        acc(4'h5, 1'b0, 8'h00);
        acc(4'h6, 1'b0, 8'h10);
        acc(4'h7, 1'b0, 8'h00);
        acc(4'he, 1'b0, 8'h21);
        acc(4'hf, 1'b0, 8'h21);
        repeat (5) begin
            @(posedge clk);
            ext_pin <= 1'b1;
            repeat (2) @(posedge clk);
            ext_pin <= 1'b0;
            @(posedge clk);
        end
        acc(4'he, 1'b0, 8'h00);
        acc(4'hf, 1'b0, 8'h00);
        rd(4'h4, 8'h1b);
        rd(4'h6, 8'h0b);
        // Timer B counting timer A underflows, four of them
        acc(4'h6, 1'b0, 8'h05);
        acc(4'h7, 1'b0, 8'h00);
        acc(4'h4, 1'b0, 8'h03);
        acc(4'h5, 1'b0, 8'h00);
        acc(4'hf, 1'b0, 8'h41);
        acc(4'he, 1'b0, 8'h01);
        edges(16);
        acc(4'he, 1'b0, 8'h00);
        acc(4'hf, 1'b0, 8'h00);
        rd(4'h6, 8'h01);
        end_sim();
    end
endmodule
